// ---- rtl/dmc_regs.svh ----
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH

// Mode register width, reset value and field positions
`define DMC_MR3_W 17
`define DMC_MR3_RST 17'h00000
`define DMC_MR3_MPR_EN 2
`define DMC_MR3_FUNC_HI 1
`define DMC_MR3_FUNC_LO 0
`define DMC_FUNC_PATTERN 2'h0
`define DMC_MPR_AGENT 8'haa

// Mode register selects on the bank address
`define DMC_BA_MR3 3'h3

// Address bits that steer an MPR read
`define DMC_A_ORDER 2
`define DMC_A_CHOP 12

// Command codes on ras_n, cas_n, we_n
`define DMC_CMD_MRS 3'h0
`define DMC_CMD_READ 3'h5
`define DMC_CMD_WRITE 3'h4

// Burst sizes and start positions
`define DMC_BEATS_BL8 4'h8
`define DMC_BEATS_BC4 4'h4
`define DMC_POS_LOW 3'h0
`define DMC_POS_HIGH 3'h4

// Timing counts in command clocks
`define DMC_TMOD_CYC 12
`define DMC_RL_MIN 3

`endif

// ---- rtl/dmc_pkg.sv ----
package dmc_pkg;

    typedef enum logic [4:0] {
        DMC_IDLE = 5'h01,
        DMC_WAIT = 5'h02,
        DMC_PRE = 5'h04,
        DMC_BURST = 5'h08,
        DMC_POST = 5'h10
    } dmc_state_t;

    typedef enum logic [1:0] {
        DMC_BL_FIXED8 = 2'h0,
        DMC_BL_OTF = 2'h1,
        DMC_BL_FIXED4 = 2'h2
    } dmc_bl_t;

endpackage : dmc_pkg

// ---- rtl/dmc_fifo.sv ----
`timescale 1ns/1ps

module dmc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("dmc_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Full and empty follow the fill count
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_ptr_r];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end

endmodule : dmc_fifo

// ---- rtl/dmc_mpr.sv ----
`timescale 1ns/1ps
`include "dmc_regs.svh"

module dmc_mpr #(
    parameter int DQW = 8,
    parameter int FIFO_DEPTH = 8,
    parameter int TMOD_CYC = `DMC_TMOD_CYC,
    parameter bit PRIME_ONLY = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic dll_locked,
    input wire logic [5:0] read_latency,
    input wire dmc_pkg::dmc_bl_t burst_mode,
    output logic arr_rd_req,
    output logic arr_wr_req,
    output logic arr_bc4,
    output logic [2:0] arr_ba,
    output logic [13:0] arr_addr,
    input wire logic arr_valid,
    output logic arr_ready,
    input wire logic [DQW-1:0] arr_data,
    output logic mrs_other,
    output logic [`DMC_MR3_W-1:0] mr3_value,
    output logic mpr_active,
    output logic read_busy,
    output logic [DQW-1:0] dq_out,
    output logic dq_oe,
    output logic dqs_out,
    output logic dqs_oe
);
    import dmc_pkg::*;

    if (!(DQW == 4 || DQW == 8 || DQW == 16) || TMOD_CYC < 1) begin : g_bad
        $error("dmc_mpr: DQW must be 4, 8 or 16 and TMOD_CYC at least 1");
    end

    localparam int CW = $clog2(TMOD_CYC + 1);
    localparam logic [7:0] AGENT = `DMC_MPR_AGENT;

    // Value of one beat: agent bit at the burst position, placed on the lanes
    function automatic logic [DQW-1:0] mpr_beat(input logic [2:0] pos, input logic ok);
        logic b;
        logic [DQW-1:0] v;
        b = ok & AGENT[pos];
        v = '0;
        if (PRIME_ONLY) begin
            v[0] = b;
            if (DQW == 16) begin
                v[DQW/2] = b;
            end
        end else begin
            v = {DQW{b}};
        end
        return v;
    endfunction : mpr_beat

    // Command decode
    logic cmd_mrs;
    logic cmd_read;
    logic cmd_write;
    assign cmd_mrs = !cs_n && ({ras_n, cas_n, we_n} == `DMC_CMD_MRS);
    assign cmd_read = !cs_n && ({ras_n, cas_n, we_n} == `DMC_CMD_READ);
    assign cmd_write = !cs_n && ({ras_n, cas_n, we_n} == `DMC_CMD_WRITE);

    // Mode register with delayed take-over
    logic [`DMC_MR3_W-1:0] mr3_r;
    logic [`DMC_MR3_W-1:0] mr3_pend_r;
    logic pend_r;
    logic [CW-1:0] tmod_r;
    logic mpr_on;
    logic func_ok;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mr3_pend_r <= `DMC_MR3_RST;
            pend_r <= 1'b0;
            tmod_r <= '0;
        end else if (cmd_mrs && ba == `DMC_BA_MR3) begin
            mr3_pend_r <= `DMC_MR3_W'(addr);
            pend_r <= 1'b1;
            tmod_r <= CW'(TMOD_CYC - 1);
        end else if (pend_r) begin
            if (tmod_r == '0) begin
                pend_r <= 1'b0;
            end else begin
                tmod_r <= tmod_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mr3_r <= `DMC_MR3_RST;
        end else if (pend_r && tmod_r == '0) begin
            mr3_r <= mr3_pend_r;
        end
    end

    assign mpr_on = mr3_r[`DMC_MR3_MPR_EN];
    // Function bits only matter when MPR is on
    assign func_ok = mr3_r[`DMC_MR3_FUNC_HI:`DMC_MR3_FUNC_LO] == `DMC_FUNC_PATTERN;
    assign mr3_value = mr3_r;
    assign mpr_active = mpr_on;

    // Other mode registers are passed on to the rest of the device
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mrs_other <= 1'b0;
        end else begin
            mrs_other <= cmd_mrs && ba != `DMC_BA_MR3;
        end
    end

    // Read burst sequencer
    dmc_state_t state_r;
    dmc_state_t state_nxt;
    logic [5:0] lat_r;
    logic [2:0] beat_r;
    logic [2:0] beat_nxt;
    logic [3:0] nbeats_r;
    logic [2:0] start_r;
    logic use_mpr_r;
    logic ok_r;
    logic take_read;
    logic chop;
    logic [5:0] rl_eff;

    assign take_read = cmd_read && state_r == DMC_IDLE && dll_locked;
    assign rl_eff = (read_latency < 6'(`DMC_RL_MIN)) ? 6'(`DMC_RL_MIN) : read_latency;

    always_comb begin
        case (burst_mode)
            DMC_BL_FIXED4: chop = 1'b1;
            DMC_BL_OTF: chop = !addr[`DMC_A_CHOP];
            default: chop = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        beat_nxt = beat_r;
        case (state_r)
            DMC_IDLE: begin
                if (take_read) begin
                    state_nxt = DMC_WAIT;
                end
            end
            DMC_WAIT: begin
                if (lat_r == '0) begin
                    state_nxt = DMC_PRE;
                end
            end
            DMC_PRE: begin
                state_nxt = DMC_BURST;
                beat_nxt = '0;
            end
            DMC_BURST: begin
                if (4'(beat_r) == nbeats_r - 4'h1) begin
                    state_nxt = DMC_POST;
                end else begin
                    beat_nxt = beat_r + 3'h1;
                end
            end
            DMC_POST: begin
                state_nxt = DMC_IDLE;
            end
            default: begin
                state_nxt = DMC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r <= DMC_IDLE;
            beat_r <= '0;
        end else begin
            state_r <= state_nxt;
            beat_r <= beat_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            lat_r <= '0;
        end else if (take_read) begin
            lat_r <= rl_eff - 6'(`DMC_RL_MIN);
        end else if (state_r == DMC_WAIT && lat_r != '0) begin
            lat_r <= lat_r - 6'h1;
        end
    end

    // Burst parameters latched with the command; other address bits ignored
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            use_mpr_r <= 1'b0;
            ok_r <= 1'b0;
            nbeats_r <= `DMC_BEATS_BL8;
            start_r <= `DMC_POS_LOW;
        end else if (take_read) begin
            use_mpr_r <= mpr_on;
            ok_r <= func_ok;
            nbeats_r <= chop ? `DMC_BEATS_BC4 : `DMC_BEATS_BL8;
            if (chop && addr[`DMC_A_ORDER]) begin
                start_r <= `DMC_POS_HIGH;
            end else begin
                start_r <= `DMC_POS_LOW;
            end
        end
    end

    // Array requests only while MPR is off
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            arr_rd_req <= 1'b0;
            arr_wr_req <= 1'b0;
            arr_bc4 <= 1'b0;
            arr_ba <= '0;
            arr_addr <= '0;
        end else begin
            arr_rd_req <= take_read && !mpr_on;
            arr_wr_req <= cmd_write && !mpr_on;
            if ((take_read || cmd_write) && !mpr_on) begin
                arr_bc4 <= chop;
                arr_ba <= ba;
                arr_addr <= addr;
            end
        end
    end

    // Array read data buffered ahead of the burst
    logic fifo_valid;
    logic fifo_pop;
    logic [DQW-1:0] fifo_data;

    assign fifo_pop = state_nxt == DMC_BURST && !use_mpr_r;

    dmc_fifo #(
        .WIDTH(DQW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(arr_valid),
        .in_ready(arr_ready),
        .in_data(arr_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Data and strobe drive
    logic [DQW-1:0] dq_r;
    logic dq_oe_r;
    logic dqs_r;
    logic dqs_oe_r;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dq_r <= '0;
            dq_oe_r <= 1'b0;
        end else if (state_nxt == DMC_BURST) begin
            dq_oe_r <= 1'b1;
            if (use_mpr_r) begin
                dq_r <= mpr_beat(start_r + beat_nxt, ok_r);
            end else begin
                dq_r <= fifo_valid ? fifo_data : '0;
            end
        end else begin
            dq_r <= '0;
            dq_oe_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dqs_r <= 1'b0;
            dqs_oe_r <= 1'b0;
        end else begin
            case (state_nxt)
                DMC_PRE: begin
                    dqs_r <= 1'b0;
                    dqs_oe_r <= 1'b1;
                end
                DMC_BURST: begin
                    dqs_r <= !beat_nxt[0];
                    dqs_oe_r <= 1'b1;
                end
                DMC_POST: begin
                    dqs_r <= 1'b0;
                    dqs_oe_r <= 1'b1;
                end
                default: begin
                    dqs_r <= 1'b0;
                    dqs_oe_r <= 1'b0;
                end
            endcase
        end
    end

    assign dq_out = dq_r;
    assign dq_oe = dq_oe_r;
    assign dqs_out = dqs_r;
    assign dqs_oe = dqs_oe_r;
    assign read_busy = state_r != DMC_IDLE;

endmodule : dmc_mpr

// ---- dv/dmc_mpr_props.sv ----
`timescale 1ns/1ps
`include "dmc_regs.svh"
module dmc_mpr_props #(
    parameter int DQW = 8,
    parameter int TMOD_CYC = 12
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic dll_locked,
    input wire logic arr_rd_req,
    input wire logic arr_wr_req,
    input wire logic mrs_other,
    input wire logic [`DMC_MR3_W-1:0] mr3_value,
    input wire logic mpr_active,
    input wire logic read_busy,
    input wire logic [DQW-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic dqs_out,
    input wire logic dqs_oe
);
    localparam int TM = TMOD_CYC + 1;
    logic is_mrs, is_rd, is_wr;
    assign is_mrs = !cs_n && !ras_n && !cas_n && !we_n;
    assign is_rd = !cs_n && ras_n && !cas_n && we_n;
    assign is_wr = !cs_n && ras_n && !cas_n && !we_n;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_mrs_load: assert property (is_mrs && ba == 3'h3 |-> ##TM
        mr3_value == {3'h0, $past(addr, TM)}) else $error("mode register load wrong");
    chk_other_mr: assert property (is_mrs && ba != 3'h3 |=> mrs_other)
        else $error("other mode register not flagged");
    chk_mpr_flag: assert property (mpr_active == mr3_value[2])
        else $error("mpr flag differs from register");
    chk_wr_array: assert property (is_wr && !mpr_active |=> arr_wr_req)
        else $error("array write missing");
    chk_rd_array: assert property (is_rd && !read_busy && dll_locked && !mpr_active
        |=> arr_rd_req) else $error("array read missing");
    chk_rd_redirect: assert property (is_rd && mpr_active |=> !arr_rd_req && !arr_wr_req)
        else $error("array touched in mpr mode");
    chk_dll_gate: assert property (is_rd && !read_busy && !dll_locked |=> !read_busy)
        else $error("read taken without dll lock");
    chk_strobe_pre: assert property ($rose(dqs_oe) |-> !dqs_out && !dq_oe ##1 dq_oe
        && dqs_out) else $error("preamble wrong");
    chk_first_beat: assert property ($rose(dq_oe) && mpr_active |-> dq_out == '0)
        else $error("first beat not lsb");
    chk_alt_pattern: assert property (dq_oe && $past(dq_oe) && mpr_active
        && mr3_value[1:0] == 2'h0 |-> dq_out[0] != $past(dq_out[0]))
        else $error("pattern not alternating");
    chk_prime_lane: assert property (dq_oe && mpr_active |-> dq_out[DQW-1:1] == '0)
        else $error("non prime lane driven");
    chk_rfu_low: assert property (dq_oe && mpr_active && mr3_value[1:0] != 2'h0
        |-> dq_out == '0) else $error("reserved code gave data");
    chk_dqs_toggle: assert property (dq_oe |-> dqs_out != $past(dqs_out))
        else $error("strobe not toggling");
    chk_quiet_idle: assert property (!read_busy |-> !dq_oe)
        else $error("data driven while idle");
endmodule : dmc_mpr_props

bind dmc_mpr dmc_mpr_props #(.DQW(DQW), .TMOD_CYC(TMOD_CYC)) i_props (
    .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dll_locked(dll_locked),
    .arr_rd_req(arr_rd_req), .arr_wr_req(arr_wr_req), .mrs_other(mrs_other),
    .mr3_value(mr3_value), .mpr_active(mpr_active), .read_busy(read_busy),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

// ---- dv/dmc_ctl_model.sv ----
`timescale 1ns/1ps
module dmc_ctl_model (
    input wire logic clk_sys,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] ba,
    output logic [13:0] addr
);
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 3'h0;
        addr = 14'h0000;
    end
    // One command cycle from a falling edge, then deselect with address inverted
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        @(negedge clk_sys);
        {cs_n, ras_n, cas_n, we_n} <= 4'hf;
        ba <= ~b;
        addr <= ~a;
    endtask : issue
    // Caller keeps banks idle and waits tMRD/tMOD around it
    task automatic mrs(input logic [2:0] b, input logic [13:0] a);
        issue(4'h0, b, (b == 3'h3) ? (a & 14'h000f) : a);
    endtask : mrs
    // Only reads and mode register sets are sent while mpr mode is on
    task automatic rd(input logic [2:0] b, input logic [13:0] a);
        issue(4'h5, b, a & 14'h3ffc);
    endtask : rd
    task automatic wr(input logic [13:0] a);
        issue(4'h4, 3'h0, a);
    endtask : wr
endmodule : dmc_ctl_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import dmc_pkg::*;
    localparam int TMOD = 4;
    localparam int RL = 5;
    localparam logic [63:0] PAT = 64'h0100010001000100;
    logic clk_sys, rstn, dll_locked, arr_valid, arr_ready;
    logic cs_n, ras_n, cas_n, we_n, mpr_active, read_busy, dq_oe, dqs_out, dqs_oe;
    logic [2:0] ba;
    logic [13:0] addr;
    logic arr_bc4;
    logic [2:0] arr_ba;
    logic [13:0] arr_addr;
    logic [5:0] read_latency;
    logic [7:0] arr_data, dq_out;
    logic [16:0] mr3_value;
    dmc_bl_t burst_mode;
    dmc_bl_t md[5] = '{DMC_BL_FIXED8, DMC_BL_FIXED8, DMC_BL_OTF, DMC_BL_OTF, DMC_BL_FIXED4};
    logic [13:0] ad[5] = '{14'h0000, 14'h2ff8, 14'h1000, 14'h0004, 14'h0000};
    int nb[5] = '{8, 8, 8, 4, 4};
    int n_fail, checked;

    dmc_ctl_model i_ctl (.clk_sys(clk_sys), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr));
    dmc_mpr #(.TMOD_CYC(TMOD)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
        .dll_locked(dll_locked), .read_latency(read_latency), .burst_mode(burst_mode),
        .arr_rd_req(), .arr_wr_req(), .arr_bc4(arr_bc4), .arr_ba(arr_ba), .arr_addr(arr_addr),
        .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_data(arr_data), .mrs_other(),
        .mr3_value(mr3_value), .mpr_active(mpr_active), .read_busy(read_busy),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
            n_fail++;
        end
    endtask : chk

    task automatic settle;
        repeat (TMOD + 2) @(negedge clk_sys);
    endtask : settle

    task automatic burst(input int n, input logic [63:0] exp, input string what);
        int cnt;
        logic [63:0] got;
        cnt = 0;
        got = '0;
        while (dq_oe !== 1'b1 && cnt < 20) begin
            @(negedge clk_sys);
            cnt++;
        end
        chk(64'(cnt + 1), 64'(RL), "read latency");
        for (int k = 0; k < n; k++) begin
            got[k*8+:8] = dq_out;
            @(negedge clk_sys);
        end
        chk(got, exp, what);
        repeat (2) @(negedge clk_sys);
    endtask : burst

    task automatic print_verdict;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end

    initial begin
        rstn = 1'b0;
        dll_locked = 1'b1;
        read_latency = 6'(RL);
        burst_mode = DMC_BL_FIXED8;
        arr_valid = 1'b0;
        arr_data = 8'h00;
        n_fail = 0;
        checked = 0;
        repeat (12) @(negedge clk_sys);
        rstn <= 1'b1;
        @(negedge clk_sys);
        i_ctl.mrs(3'h3, 14'h0003);
        settle();
        chk(64'({mpr_active, mr3_value}), 64'h3, "function bits with mpr off");
        i_ctl.wr(14'h0010);
        chk(64'({arr_ba, arr_addr}), 64'h0010, "array write address");
        for (int i = 0; i <= 8; i++) begin
            arr_valid <= 1'b1;
            arr_data <= 8'h10 + 8'(i);
            @(negedge clk_sys);
        end
        chk(64'(arr_ready), 64'h0, "fifo full refuses");
        arr_valid <= 1'b0;
        i_ctl.rd(3'h0, 14'h0000);
        burst(8, 64'h1716151413121110, "array read");
        chk(64'(arr_ready), 64'h1, "fifo drained");
        chk(64'(arr_bc4), 64'h0, "array read length");
        i_ctl.mrs(3'h1, 14'h0155);
        settle();
        chk(64'(mr3_value), 64'h3, "register kept");
        $display("test array done");
        i_ctl.mrs(3'h3, 14'h0004);
        settle();
        chk(64'(mr3_value), 64'h4, "mpr enabled");
        for (int i = 0; i < 5; i++) begin
            burst_mode <= md[i];
            i_ctl.rd((i == 1) ? 3'h7 : 3'h0, ad[i]);
            burst(nb[i], (nb[i] == 8) ? PAT : {32'h0, PAT[31:0]}, "mpr read");
        end
        chk(64'({arr_bc4, arr_ba, arr_addr}), 64'h0, "array untouched in mpr");
        dll_locked <= 1'b0;
        i_ctl.rd(3'h0, 14'h0000);
        repeat (RL) @(negedge clk_sys);
        chk(64'({read_busy, dq_oe, dqs_oe}), 64'h0, "read without lock");
        dll_locked <= 1'b1;
        $display("test mpr done");
        burst_mode <= DMC_BL_FIXED8;
        for (int c = 1; c < 4; c++) begin
            i_ctl.mrs(3'h3, 14'h0004 | 14'(c));
            settle();
            i_ctl.rd(3'h0, 14'h0000);
            burst(8, 64'h0, "reserved code");
        end
        $display("test reserved done");
        i_ctl.mrs(3'h3, 14'h0000);
        settle();
        chk(64'({mpr_active, mr3_value}), 64'h0, "mpr left");
        i_ctl.mrs(3'h3, 14'h0004);
        settle();
        i_ctl.rd(3'h0, 14'h0000);
        repeat (RL + 2) @(negedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(negedge clk_sys);
        rstn <= 1'b1;
        @(negedge clk_sys);
        chk(64'({mpr_active, dq_oe, dqs_oe, read_busy, mr3_value}), 64'h0, "reset in mpr");
        $display("test reset done");
        print_verdict();
    end
endmodule : tb_top
